// ===== verilog/ppc_pkg.sv
// Register map, field layout and reset values of the port configuration unit.
// Assumes an 8-bit register address space reached over a plain strobe port.
package ppc_pkg;
    localparam logic [7:0] ADDR_P2_DATA = 8'he2;
    localparam logic [7:0] ADDR_P3_DATA = 8'he3;
    localparam logic [7:0] ADDR_P2_MODE_HI = 8'he4;
    localparam logic [7:0] ADDR_P2_MODE_LO = 8'he5;
    localparam logic [7:0] ADDR_P3_MODE_HI = 8'he6;
    localparam logic [7:0] ADDR_P3_MODE_LO = 8'he7;
    localparam logic [7:0] ADDR_P1_MODE_LO = 8'he9;
    localparam logic [7:0] ADDR_P1_IRQ_EN = 8'hea;
    localparam logic [7:0] ADDR_P1_IRQ_PEND = 8'heb;
    localparam logic [7:0] ADDR_P1_DATA = 8'he1;
    localparam logic [7:0] ADDR_P2_PULLUP = 8'hfa;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'hf0;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'hf1;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hf2;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_PULLUP = 8'h00;
    localparam logic [3:0] RST_NIBBLE = 4'h0;
    // Two-bit pin modes
    localparam logic [1:0] MODE_IN = 2'h0;
    localparam logic [1:0] MODE_IN_PU = 2'h1;
    localparam logic [1:0] MODE_PP = 2'h2;
    localparam logic [1:0] MODE_ALT = 2'h3;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;
endpackage

// ===== verilog/ppc_port_pin_config_unit.sv
// Port 1 low nibble, port 2 and port 3 pin configuration and data; port 1 edge interrupts.
// Assumes pins synchronous to mclk_i; peripherals enable their own alternate functions.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module ppc_port_pin_config_unit (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic [3:0] p1_pin_i,
    output logic [3:0] p1_pin_o,
    output logic [3:0] p1_pin_oe_o,
    output logic [3:0] p1_pullup_o,
    input wire logic [7:0] p2_pin_i,
    output logic [7:0] p2_pin_o,
    output logic [7:0] p2_pin_oe_o,
    output logic [7:0] p2_pullup_o,
    input wire logic [7:0] p3_pin_i,
    output logic [7:0] p3_pin_o,
    output logic [7:0] p3_pin_oe_o,
    input wire logic timer_one_output_zero_i,
    input wire logic buzzer_out_i,
    input wire logic timer_a_output_i,
    input wire logic [7:0] p2_alt_out_i,
    input wire logic [7:0] p3_alt_out_i,
    output logic [3:0] ext_irq_o,
    output logic timer_a_capture_in_o,
    output logic timer_a_ext_clock_o,
    output logic irq_o
);
    // Mode field of pin n out of a packed byte pair
    function automatic logic [1:0] mode_of(input logic [15:0] modes, input int n);
        mode_of = modes[2*n +: 2];
    endfunction

    localparam logic [3:0] RST_NIBBLE_W = ppc_pkg::RST_NIBBLE;
    logic [7:0] p1_mode_q;
    logic [7:0] p2_mode_hi_q;
    logic [7:0] p2_mode_lo_q;
    logic [7:0] p3_mode_hi_q;
    logic [7:0] p3_mode_lo_q;
    logic [3:0] p1_data_q;
    logic [7:0] p2_data_q;
    logic [7:0] p3_data_q;
    logic [7:0] p2_pullup_q;
    logic [3:0] p1_irq_en_q;
    logic [3:0] p1_pend_q;
    logic [3:0] p1_prev_q;
    logic [3:0] irq_stat_q;
    logic [3:0] irq_mask_q;
    logic [7:0] rdata_q;
    logic [3:0] p1_edge;
    logic [7:0] p1_rd;
    logic [7:0] p2_rd;
    logic [7:0] p3_rd;
    logic [15:0] p2_modes;
    logic [15:0] p3_modes;
    logic [15:0] p1_modes;

    assign p1_modes = {8'h00, p1_mode_q};
    assign p2_modes = {p2_mode_hi_q, p2_mode_lo_q};
    assign p3_modes = {p3_mode_hi_q, p3_mode_lo_q};

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            p1_mode_q <= ppc_pkg::RST_MODE;
        end else if (wr_i && addr_i == ppc_pkg::ADDR_P1_MODE_LO) begin
            p1_mode_q <= wdata_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            p2_mode_hi_q <= ppc_pkg::RST_MODE;
            p2_mode_lo_q <= ppc_pkg::RST_MODE;
        end else if (wr_i) begin
            if (addr_i == ppc_pkg::ADDR_P2_MODE_HI) begin
                p2_mode_hi_q <= wdata_i;
            end
            if (addr_i == ppc_pkg::ADDR_P2_MODE_LO) begin
                p2_mode_lo_q <= wdata_i;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            p3_mode_hi_q <= ppc_pkg::RST_MODE;
            p3_mode_lo_q <= ppc_pkg::RST_MODE;
        end else if (wr_i) begin
            if (addr_i == ppc_pkg::ADDR_P3_MODE_HI) begin
                p3_mode_hi_q <= wdata_i;
            end
            if (addr_i == ppc_pkg::ADDR_P3_MODE_LO) begin
                p3_mode_lo_q <= wdata_i;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            p1_data_q <= ppc_pkg::RST_NIBBLE;
            p2_data_q <= ppc_pkg::RST_DATA;
            p3_data_q <= ppc_pkg::RST_DATA;
        end else if (wr_i) begin
            if (addr_i == ppc_pkg::ADDR_P1_DATA) begin
                p1_data_q <= wdata_i[3:0];
            end
            if (addr_i == ppc_pkg::ADDR_P2_DATA) begin
                p2_data_q <= wdata_i;
            end
            if (addr_i == ppc_pkg::ADDR_P3_DATA) begin
                p3_data_q <= wdata_i;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            p2_pullup_q <= ppc_pkg::RST_PULLUP;
        end else if (wr_i && addr_i == ppc_pkg::ADDR_P2_PULLUP) begin
            p2_pullup_q <= wdata_i;
        end
    end

    // Port 1 pin drivers; the alternate outputs come from the peripherals
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            p1_pin_o <= RST_NIBBLE_W;
            p1_pin_oe_o <= RST_NIBBLE_W;
            p1_pullup_o <= RST_NIBBLE_W;
        end else begin
            for (int n = 0; n < 4; n++) begin
                p1_pin_o[n] <= p1_data_q[n];
                p1_pin_oe_o[n] <= (mode_of(p1_modes, n) == ppc_pkg::MODE_PP);
                p1_pullup_o[n] <= (mode_of(p1_modes, n) == ppc_pkg::MODE_IN_PU);
            end
            if (mode_of(p1_modes, 3) == ppc_pkg::MODE_ALT) begin
                p1_pin_o[3] <= timer_one_output_zero_i;
                p1_pin_oe_o[3] <= 1'b1;
            end
            if (mode_of(p1_modes, 1) == ppc_pkg::MODE_ALT) begin
                p1_pin_o[1] <= buzzer_out_i;
                p1_pin_oe_o[1] <= 1'b1;
            end
            if (mode_of(p1_modes, 0) == ppc_pkg::MODE_ALT) begin
                p1_pin_o[0] <= timer_a_output_i;
                p1_pin_oe_o[0] <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            p2_pin_o <= ppc_pkg::RST_DATA;
            p2_pin_oe_o <= ppc_pkg::RST_DATA;
            p2_pullup_o <= ppc_pkg::RST_PULLUP;
            p3_pin_o <= ppc_pkg::RST_DATA;
            p3_pin_oe_o <= ppc_pkg::RST_DATA;
        end else begin
            p2_pullup_o <= p2_pullup_q;
            for (int n = 0; n < 8; n++) begin
                unique case (mode_of(p2_modes, n))
                    ppc_pkg::MODE_PP: begin
                        p2_pin_o[n] <= p2_data_q[n];
                        p2_pin_oe_o[n] <= 1'b1;
                    end
                    ppc_pkg::MODE_ALT: begin
                        p2_pin_o[n] <= p2_alt_out_i[n];
                        p2_pin_oe_o[n] <= 1'b1;
                    end
                    default: begin
                        p2_pin_o[n] <= p2_data_q[n];
                        p2_pin_oe_o[n] <= 1'b0;
                    end
                endcase
                // Open-drain (code 01) only ever pulls low
                unique case (mode_of(p3_modes, n))
                    ppc_pkg::MODE_IN_PU: begin
                        p3_pin_o[n] <= 1'b0;
                        p3_pin_oe_o[n] <= ~p3_data_q[n];
                    end
                    ppc_pkg::MODE_PP: begin
                        p3_pin_o[n] <= p3_data_q[n];
                        p3_pin_oe_o[n] <= 1'b1;
                    end
                    ppc_pkg::MODE_ALT: begin
                        p3_pin_o[n] <= p3_alt_out_i[n];
                        p3_pin_oe_o[n] <= 1'b1;
                    end
                    default: begin
                        p3_pin_o[n] <= p3_data_q[n];
                        p3_pin_oe_o[n] <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Peripheral inputs: each input pin feeds its external interrupt line
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_irq_o <= RST_NIBBLE_W;
            timer_a_capture_in_o <= 1'b0;
            timer_a_ext_clock_o <= 1'b0;
            p1_prev_q <= RST_NIBBLE_W;
        end else begin
            p1_prev_q <= p1_pin_i;
            for (int n = 0; n < 4; n++) begin
                ext_irq_o[n] <= p1_pin_i[n] & ~p1_mode_q[2*n+1];
            end
            timer_a_capture_in_o <= p1_pin_i[2] & ~p1_mode_q[5];
            timer_a_ext_clock_o <= p1_pin_i[1] & ~p1_mode_q[3];
        end
    end

    // Edge detect on input-mode port 1 pins
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            p1_edge[n] = (p1_pin_i[n] ^ p1_prev_q[n]) & ~p1_mode_q[2*n+1];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            p1_pend_q <= RST_NIBBLE_W;
        end else begin
            if (wr_i && addr_i == ppc_pkg::ADDR_P1_IRQ_PEND) begin
                p1_pend_q <= (p1_pend_q & wdata_i[3:0]) | (p1_edge & p1_irq_en_q);
            end else begin
                p1_pend_q <= p1_pend_q | (p1_edge & p1_irq_en_q);
            end
        end
    end

    // Sticky status mirrors pending events; set wins over clear
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_stat_q <= RST_NIBBLE_W;
            irq_mask_q <= RST_NIBBLE_W;
            p1_irq_en_q <= RST_NIBBLE_W;
        end else begin
            if (wr_i && addr_i == ppc_pkg::ADDR_P1_IRQ_EN) begin
                p1_irq_en_q <= wdata_i[3:0];
            end
            if (wr_i && addr_i == ppc_pkg::ADDR_IRQ_ENABLE) begin
                irq_mask_q <= wdata_i[3:0];
            end
            if (wr_i && addr_i == ppc_pkg::ADDR_IRQ_CLEAR) begin
                irq_stat_q <= (irq_stat_q & ~wdata_i[3:0]) | (p1_edge & p1_irq_en_q);
            end else begin
                irq_stat_q <= irq_stat_q | (p1_edge & p1_irq_en_q);
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |((p1_pend_q | irq_stat_q) & irq_mask_q & p1_irq_en_q)
                || |(irq_stat_q & irq_mask_q);
        end
    end

    always_comb begin
        p1_rd = 8'h00;
        for (int n = 0; n < 8; n++) begin
            p2_rd[n] = p2_pin_oe_o[n] ? p2_data_q[n] : p2_pin_i[n];
            p3_rd[n] = p3_pin_oe_o[n] ? p3_data_q[n] : p3_pin_i[n];
        end
        for (int n = 0; n < 4; n++) begin
            p1_rd[n] = p1_pin_oe_o[n] ? p1_data_q[n] : p1_pin_i[n];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= ppc_pkg::RD_UNMAPPED;
        end else if (rd_i) begin
            unique case (addr_i)
                ppc_pkg::ADDR_P1_DATA: rdata_q <= p1_rd;
                ppc_pkg::ADDR_P2_DATA: rdata_q <= p2_rd;
                ppc_pkg::ADDR_P3_DATA: rdata_q <= p3_rd;
                ppc_pkg::ADDR_P1_MODE_LO: rdata_q <= p1_mode_q;
                ppc_pkg::ADDR_P2_MODE_HI: rdata_q <= p2_mode_hi_q;
                ppc_pkg::ADDR_P2_MODE_LO: rdata_q <= p2_mode_lo_q;
                ppc_pkg::ADDR_P3_MODE_HI: rdata_q <= p3_mode_hi_q;
                ppc_pkg::ADDR_P3_MODE_LO: rdata_q <= p3_mode_lo_q;
                ppc_pkg::ADDR_P2_PULLUP: rdata_q <= p2_pullup_q;
                ppc_pkg::ADDR_P1_IRQ_EN: rdata_q <= {4'h0, p1_irq_en_q};
                ppc_pkg::ADDR_P1_IRQ_PEND: rdata_q <= {4'h0, p1_pend_q};
                ppc_pkg::ADDR_IRQ_STATUS: rdata_q <= {4'h0, irq_stat_q};
                ppc_pkg::ADDR_IRQ_ENABLE: rdata_q <= {4'h0, irq_mask_q};
                default: rdata_q <= ppc_pkg::RD_UNMAPPED;
            endcase
        end else begin
            rdata_q <= ppc_pkg::RD_UNMAPPED;
        end
    end

    assign rdata_o = rdata_q;
endmodule

// ===== bench/ppc_port_pin_config_unit_asserts.sv
// Checker for the port configuration unit, bound to its top module.
// Sees only top-level ports; the port 1 mode and port 2 pull-up registers are shadowed.
`timescale 1ns/1ps
module ppc_port_pin_config_unit_asserts (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [3:0] p1_pin_i,
    input wire logic [3:0] p1_pin_o,
    input wire logic [3:0] p1_pin_oe_o,
    input wire logic [3:0] p1_pullup_o,
    input wire logic [7:0] p2_pullup_o,
    input wire logic timer_one_output_zero_i,
    input wire logic buzzer_out_i,
    input wire logic timer_a_output_i,
    input wire logic [3:0] ext_irq_o,
    input wire logic timer_a_capture_in_o,
    input wire logic timer_a_ext_clock_o
);
    logic [7:0] m_q;
    logic [7:0] pu_q;
    logic live_q;
    logic [3:0] in_m;
    logic [3:0] pu_m;
    logic [3:0] oe_m;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            m_q <= 8'h00;
            pu_q <= 8'h00;
            live_q <= 1'b0;
        end else begin
            live_q <= 1'b1;
            if (wr_i && addr_i == ppc_pkg::ADDR_P1_MODE_LO) m_q <= wdata_i;
            if (wr_i && addr_i == ppc_pkg::ADDR_P2_PULLUP) pu_q <= wdata_i;
        end
    end
    // Pin 2 code 11 has no function: neither driven nor fed to its inputs
    assign in_m = ~{m_q[7], m_q[5], m_q[3], m_q[1]};
    assign oe_m = {m_q[7], m_q[5:4] == 2'h2, m_q[3], m_q[1]};
    assign pu_m = {m_q[7:6] == 2'h1, m_q[5:4] == 2'h1, m_q[3:2] == 2'h1, m_q[1:0] == 2'h1};
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence p1_wr_s;
        wr_i && addr_i == ppc_pkg::ADDR_P1_MODE_LO;
    endsequence
    sequence p1_rd_s;
        rd_i && addr_i == ppc_pkg::ADDR_P1_MODE_LO;
    endsequence
    read_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    mode_readback_a: assert property (p1_rd_s |=> rdata_o == $past(m_q))
        else $error("port 1 mode read back wrong");
    mode_wr_rd_a: assert property (p1_wr_s ##2 p1_rd_s |=> rdata_o == $past(wdata_i, 3))
        else $error("port 1 mode write not read back");
    p1_drive_a: assert property (p1_pin_oe_o == $past(oe_m))
        else $error("port 1 drive enable wrong for mode");
    p1_pullup_a: assert property (p1_pullup_o == $past(pu_m))
        else $error("port 1 pull-up wrong for mode");
    timer_a_output_route_a: assert property ($past(m_q[1:0]) == 2'h3 |-> p1_pin_o[0] == $past(timer_a_output_i))
        else $error("timer A output not on pin 0");
    buzzer_route_a: assert property ($past(m_q[3:2]) == 2'h3 |-> p1_pin_o[1] == $past(buzzer_out_i))
        else $error("buzzer not on pin 1");
    t1out_route_a: assert property ($past(m_q[7:6]) == 2'h3 |-> p1_pin_o[3] == $past(timer_one_output_zero_i))
        else $error("timer 1 output not on pin 3");
    irq_feed_a: assert property (live_q |-> ext_irq_o == $past(p1_pin_i & in_m))
        else $error("external irq inputs wrong");
    timer_feed_a: assert property (live_q |-> {timer_a_capture_in_o, timer_a_ext_clock_o} ==
        $past({p1_pin_i[2] & in_m[2], p1_pin_i[1] & in_m[1]}))
        else $error("timer A capture or clock feed wrong");
    p2_pullup_a: assert property (p2_pullup_o == $past(pu_q))
        else $error("port 2 pull-ups differ from register");
endmodule

bind ppc_port_pin_config_unit ppc_port_pin_config_unit_asserts u_chk (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .p1_pin_i(p1_pin_i), .p1_pin_o(p1_pin_o),
    .p1_pin_oe_o(p1_pin_oe_o), .p1_pullup_o(p1_pullup_o), .p2_pullup_o(p2_pullup_o),
    .timer_one_output_zero_i(timer_one_output_zero_i), .buzzer_out_i(buzzer_out_i),
    .timer_a_output_i(timer_a_output_i), .ext_irq_o(ext_irq_o),
    .timer_a_capture_in_o(timer_a_capture_in_o), .timer_a_ext_clock_o(timer_a_ext_clock_o)
);

// ===== bench/ppc_board_model.sv
// Board circuitry on one port: the unit's drive, a board driver and pull-ups.
// An undriven pin without pull-up toggles each cycle so it never looks held.
`timescale 1ns/1ps
module ppc_board_model #(
    parameter int W = 8
) (
    input wire logic mclk_i,
    input wire logic [W-1:0] drive_i,
    input wire logic [W-1:0] oe_i,
    input wire logic [W-1:0] pu_i,
    input wire logic [W-1:0] ext_i,
    input wire logic [W-1:0] ext_en_i,
    output logic [W-1:0] pin_o
);
    logic [W-1:0] float_q = '0;
    always_ff @(posedge mclk_i) begin
        float_q <= ~float_q;
    end
    assign pin_o = (oe_i & drive_i) | (~oe_i & ext_en_i & ext_i) |
        (~oe_i & ~ext_en_i & (pu_i | float_q));
endmodule

// ===== bench/ppc_port_pin_config_unit_tb.sv
// Self-checking bench for the port configuration unit.
// Reads are scored from a queue; board models resolve all pins.
`timescale 1ns/1ps
module ppc_port_pin_config_unit_tb;
    logic mclk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, rd_d = 0, rnd_p1 = 1;
    logic [7:0] addr_i = 0, wdata_i = 0, rdata_o, p2_alt = 0, p3_alt = 0;
    logic [3:0] p1_pin_i, p1_pin_o, p1_pin_oe_o, p1_pullup_o, ext_irq_o, e1v = 0, e1en = 4'hf;
    logic [7:0] p2_pin_i, p2_pin_o, p2_pin_oe_o, p2_pullup_o, e2v = 0, e2en = 8'hff;
    logic [7:0] p3_pin_i, p3_pin_o, p3_pin_oe_o, e3v = 0, e3en = 8'hff, e3pu = 8'h00;
    logic t1o = 0, buzzer_out = 0, tao = 0, timer_a_capture_in, timer_a_ext_clock, irq_o;
    logic [7:0] exp_q[$];
    int errors = 0, n_tests = 0, seed = 16;
    always #2.5 mclk_i = ~mclk_i;
    ppc_port_pin_config_unit uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .p1_pin_i(p1_pin_i),
        .p1_pin_o(p1_pin_o), .p1_pin_oe_o(p1_pin_oe_o), .p1_pullup_o(p1_pullup_o),
        .p2_pin_i(p2_pin_i), .p2_pin_o(p2_pin_o), .p2_pin_oe_o(p2_pin_oe_o),
        .p2_pullup_o(p2_pullup_o), .p3_pin_i(p3_pin_i), .p3_pin_o(p3_pin_o),
        .p3_pin_oe_o(p3_pin_oe_o), .timer_one_output_zero_i(t1o), .buzzer_out_i(buzzer_out),
        .timer_a_output_i(tao), .p2_alt_out_i(p2_alt), .p3_alt_out_i(p3_alt),
        .ext_irq_o(ext_irq_o), .timer_a_capture_in_o(timer_a_capture_in), .timer_a_ext_clock_o(timer_a_ext_clock),
        .irq_o(irq_o));
    ppc_board_model #(.W(4)) b1 (.mclk_i(mclk_i), .drive_i(p1_pin_o), .oe_i(p1_pin_oe_o),
        .pu_i(p1_pullup_o), .ext_i(e1v), .ext_en_i(e1en), .pin_o(p1_pin_i));
    ppc_board_model #(.W(8)) b2 (.mclk_i(mclk_i), .drive_i(p2_pin_o), .oe_i(p2_pin_oe_o),
        .pu_i(p2_pullup_o), .ext_i(e2v), .ext_en_i(e2en), .pin_o(p2_pin_i));
    ppc_board_model #(.W(8)) b3 (.mclk_i(mclk_i), .drive_i(p3_pin_o), .oe_i(p3_pin_oe_o),
        .pu_i(e3pu), .ext_i(e3v), .ext_en_i(e3en), .pin_o(p3_pin_i));
    // Peripherals keep toggling; the port only routes them
    always @(posedge mclk_i) begin
        {t1o, buzzer_out, tao} <= 3'($random(seed));
        if (rnd_p1) e1v <= 4'($random(seed));
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    always @(posedge mclk_i) begin
        if (rd_d) chk(rdata_o, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
        rd_d <= rd_i;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task automatic summarize;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        logic [7:0] v, d;
        logic [7:0] ra[7] = '{8'he9, 8'he4, 8'he5, 8'he6, 8'he7, 8'hfa, 8'h10};
        p2_alt = 8'($random(seed));
        p3_alt = 8'($random(seed));
        idle(6);
        rst_n_i <= 1'b1;
        foreach (ra[i]) rd(ra[i], 8'h00);
        for (int c = 0; c < 12; c++) begin
            v = c < 4 ? {4{c[1:0]}} : 8'($random(seed));
            wr(ppc_pkg::ADDR_P1_MODE_LO, v);
            rd(ppc_pkg::ADDR_P1_MODE_LO, v);
            chk({4'h0, p1_pin_oe_o}, {4'h0, v[7], v[5] & ~v[4], v[3], v[1]});
        end
        d = 8'($random(seed));
        wr(ppc_pkg::ADDR_P2_MODE_HI, 8'haa);
        wr(ppc_pkg::ADDR_P2_MODE_LO, 8'haa);
        wr(ppc_pkg::ADDR_P2_DATA, d);
        rd(ppc_pkg::ADDR_P2_DATA, d);
        chk(p2_pin_o, d);
        chk(p2_pin_oe_o, 8'hff);
        wr(ppc_pkg::ADDR_P2_MODE_HI, 8'h00);
        wr(ppc_pkg::ADDR_P2_MODE_LO, 8'h00);
        wr(ppc_pkg::ADDR_P2_PULLUP, 8'hf0);
        e2en <= 8'h0f;
        e2v <= ~d;
        idle(3);
        chk(p2_pullup_o, 8'hf0);
        rd(ppc_pkg::ADDR_P2_DATA, {4'hf, ~d[3:0]});
        rd(ppc_pkg::ADDR_P2_PULLUP, 8'hf0);
        wr(ppc_pkg::ADDR_P3_MODE_HI, 8'hff);
        wr(ppc_pkg::ADDR_P3_MODE_LO, 8'haa);
        wr(ppc_pkg::ADDR_P3_DATA, d);
        idle(2);
        chk({p3_pin_o[7:4], p3_pin_o[3:0]}, {p3_alt[7:4], d[3:0]});
        wr(ppc_pkg::ADDR_P3_MODE_LO, 8'h55);
        idle(2);
        chk(p3_pin_oe_o, {4'hf, ~d[3:0]});
        e3en <= 8'h00;
        e3pu <= 8'hff;
        idle(2);
        rd(ppc_pkg::ADDR_P3_DATA, d);
        e3en <= 8'hff;
        wr(ppc_pkg::ADDR_P3_MODE_HI, 8'h00);
        wr(ppc_pkg::ADDR_P3_MODE_LO, 8'h00);
        e3v <= ~d;
        idle(3);
        rd(ppc_pkg::ADDR_P3_DATA, ~d);
        rnd_p1 <= 1'b0;
        wr(ppc_pkg::ADDR_P1_DATA, 8'h05);
        wr(ppc_pkg::ADDR_P1_MODE_LO, 8'haa);
        idle(2);
        chk({4'h0, p1_pin_o}, 8'h05);
        rd(ppc_pkg::ADDR_P1_DATA, 8'h05);
        wr(ppc_pkg::ADDR_P1_MODE_LO, 8'h55);
        e1en <= 4'h0;
        idle(3);
        rd(ppc_pkg::ADDR_P1_DATA, 8'h0f);
        e1en <= 4'hf;
        wr(ppc_pkg::ADDR_P1_MODE_LO, 8'h00);
        e1v <= 4'h1;
        idle(4);
        rd(ppc_pkg::ADDR_P1_IRQ_PEND, 8'h00);
        wr(ppc_pkg::ADDR_P1_IRQ_EN, 8'h0f);
        wr(ppc_pkg::ADDR_IRQ_CLEAR, 8'hff);
        wr(ppc_pkg::ADDR_IRQ_ENABLE, 8'h0f);
        e1v <= 4'h5;
        idle(4);
        rd(ppc_pkg::ADDR_P1_IRQ_PEND, 8'h04);
        rd(ppc_pkg::ADDR_IRQ_STATUS, 8'h04);
        chk({7'h0, irq_o}, 8'h01);
        idle(20);
        rd(ppc_pkg::ADDR_P1_IRQ_PEND, 8'h04);
        wr(ppc_pkg::ADDR_P1_IRQ_PEND, 8'h00);
        wr(ppc_pkg::ADDR_IRQ_ENABLE, 8'h00);
        idle(2);
        chk({7'h0, irq_o}, 8'h00);
        wr(ppc_pkg::ADDR_IRQ_ENABLE, 8'h0f);
        idle(2);
        chk({7'h0, irq_o}, 8'h01);
        wr(ppc_pkg::ADDR_IRQ_CLEAR, 8'h0f);
        idle(2);
        chk({7'h0, irq_o}, 8'h00);
        rd(ppc_pkg::ADDR_P1_IRQ_PEND, 8'h00);
        rd(ppc_pkg::ADDR_IRQ_CLEAR, 8'h00);
        for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge mclk_i);
        if (exp_q.size() > 0) errors++;
        summarize();
    end
endmodule
